//--- hdl/mmi_defines.svh
// Behaviour
// - Selected module answers serial bus commands
// - Deselected module ignores every serial transaction
// - Long reset pulse restores all writable defaults
// - Init time starts at reset pin release
// - Completion shown by interrupt, pending bit clear
// - Power-up raises completion interrupt without reset
// - Low power request selects reduced power state
// - Presence output held low while plugged
// - Interrupt pin low on fault or status
// - Interrupt pin is open drain only
// - Answer at device address A0h
// - Fixed lower page plus paged upper half
// - Byte 127 selects the upper page
// - Lower bytes 0 to 85 read only
// - Bytes 86-97 and 100-106 read write
// - Page 3 thresholds read only, 240-241 writable
// - Page 0 rate, wavelength, tolerance encodings
// - Page 0 bytes 191 and 223 check codes
// - Page 0 name, part, serial, company, date
// - Flags clear on read, interrupt releases promptly
// - Select takes effect within 100 us
// - Pending flag is byte 2 bit 0
`ifndef MMI_DEFINES_SVH
`define MMI_DEFINES_SVH
`define MMI_CLK_MHZ         40
`define MMI_MIN_RESET_NS    2000
`define MMI_MIN_RESET_CYC   ((`MMI_MIN_RESET_NS * `MMI_CLK_MHZ + 999) / 1000)
`define MMI_INIT_MS         2000
`define MMI_INIT_CYC        (`MMI_INIT_MS * `MMI_CLK_MHZ * 1000)
`define MMI_INTERRUPT_N_OFF_US     500
`define MMI_INTERRUPT_N_OFF_CYC    (`MMI_INTERRUPT_N_OFF_US * `MMI_CLK_MHZ)
`define MMI_DEV_ADDR        7'h50
`define MMI_ADR_STATUS      8'h02
`define MMI_ADR_FLAG0       8'h03
`define MMI_ADR_FLAG1       8'h04
`define MMI_ADR_CTRL_LO     8'h56
`define MMI_ADR_CTRL_HI     8'h61
`define MMI_ADR_MASK_LO     8'h64
`define MMI_ADR_MASK_HI     8'h6A
`define MMI_ADR_PAGE        8'h7F
`define MMI_ADR_RATE        8'h8C
`define MMI_ADR_WAVE        8'hBA
`define MMI_ADR_TOL         8'hBC
`define MMI_ADR_TEMP        8'hBE
`define MMI_ADR_BASE_ID_CHECK_CODE     8'hBF
`define MMI_ADR_EXT_ID_CHECK_CODE      8'hDF
`define MMI_ADR_P3CTL_LO    8'hF0
`define MMI_ADR_P3CTL_HI    8'hF1
`define MMI_PAGE_ID         8'h00
`define MMI_PAGE_THR        8'h03
`define MMI_TYPE_ID         8'h5A
`define MMI_RATE_VAL        8'hFF
`define MMI_WAVE_VAL        16'h634C
`define MMI_TOL_VAL         16'h0514
`define MMI_TEMP_VAL        8'h46
`endif

//--- hdl/mmi_pkg.sv
package mmi_pkg;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_DEVADR = 5'b00010,
        ST_PTR    = 5'b00100,
        ST_WDATA  = 5'b01000,
        ST_RDATA  = 5'b10000
    } mmi_state_e;

    typedef struct packed {
        logic [15:0] flags;
        logic        pending;
    } mmi_stat_s;

    typedef struct packed {
        logic       hi;
        logic [7:0] val;
    } mmi_rdclr_s;

endpackage

//--- hdl/mmi_top.sv
`timescale 1ns/10ps
`include "mmi_defines.svh"
module mmi_top
    import mmi_pkg::*;
#(
    parameter int unsigned INIT_CYCLES     = `MMI_INIT_CYC,
    parameter int unsigned INTERRUPT_N_OFF_CYCLES = `MMI_INTERRUPT_N_OFF_CYC
)(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       SCL,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE,
    input  wire logic       MODULE_SELECT_N,
    input  wire logic       MODULE_RESET_N,
    input  wire logic       LOW_POWER_REQUEST,
    input  wire logic [7:0] FAULT_IN,
    output logic            LOW_POWER_STATE,
    output logic            MODULE_PRESENT_N,
    output logic            INTERRUPT_N_O,
    output logic            INTERRUPT_N_OE
);

    localparam logic [7:0]  MIN_RST = 8'(`MMI_MIN_RESET_CYC);
    localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);
    localparam logic [127:0] VENDOR_NAME = "GENERIC OPTICS  "; // Arbitrary
    localparam logic [127:0] VENDOR_PN   = "MMI-4LANE-0001  "; // Arbitrary
    localparam logic [127:0] VENDOR_SN   = "SN0000000000001 "; // Arbitrary
    localparam logic [23:0]  VENDOR_OUI  = 24'h000000;          // Arbitrary
    localparam logic [63:0]  DATE_CODE   = "00000000";          // Arbitrary

    if (INIT_CYCLES < 2) begin : g_bad_init
        $error("INIT_CYCLES must be at least 2");
    end
    if (INTERRUPT_N_OFF_CYCLES < 2) begin : g_bad_interrupt_n
        $error("INTERRUPT_N_OFF_CYCLES below interrupt release latency");
    end

    function automatic logic [7:0] rom0_raw(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == 8'h80)
            r = `MMI_TYPE_ID;
        else if (a == `MMI_ADR_RATE)
            r = `MMI_RATE_VAL;
        else if (a >= 8'h94 && a <= 8'hA3)
            r = VENDOR_NAME[8 * (8'hA3 - a) +: 8];
        else if (a >= 8'hA5 && a <= 8'hA7)
            r = VENDOR_OUI[8 * (8'hA7 - a) +: 8];
        else if (a >= 8'hA8 && a <= 8'hB7)
            r = VENDOR_PN[8 * (8'hB7 - a) +: 8];
        else if (a == `MMI_ADR_WAVE)
            r = 8'(`MMI_WAVE_VAL >> 8);
        else if (a == `MMI_ADR_WAVE + 8'h01)
            r = 8'(`MMI_WAVE_VAL & 16'h00FF);
        else if (a == `MMI_ADR_TOL)
            r = 8'(`MMI_TOL_VAL >> 8);
        else if (a == `MMI_ADR_TOL + 8'h01)
            r = 8'(`MMI_TOL_VAL & 16'h00FF);
        else if (a == `MMI_ADR_TEMP)
            r = `MMI_TEMP_VAL;
        else if (a >= 8'hC4 && a <= 8'hD3)
            r = VENDOR_SN[8 * (8'hD3 - a) +: 8];
        else if (a >= 8'hD4 && a <= 8'hDB)
            r = DATE_CODE[8 * (8'hDB - a) +: 8];
        return r;
    endfunction

    function automatic logic [7:0] sum8(input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 256; i++)
            if (i >= lo && i <= hi)
                s = s + rom0_raw(8'(i));
        return s;
    endfunction

    // Check codes folded at elaboration
    localparam logic [7:0] BASE_ID_CHECK_CODE_VAL = sum8(8'h80, 8'hBE);
    localparam logic [7:0] EXT_ID_CHECK_CODE_VAL  = sum8(8'hC0, 8'hDE);

    // ---------------- CLK domain ----------------
    logic [1:0]  rstpin_s_q;
    logic [1:0]  lp_s_q;
    logic [7:0]  flt_s1_q, flt_s2_q;
    logic [15:0] msk_s1_q, msk_s2_q;
    logic [2:0]  rdclr_s_q;
    logic [7:0]  rst_low_cnt_q;
    logic        mod_rst_q;
    logic [31:0] init_cnt_q;
    logic        init_busy_q;
    logic [15:0] flags_q;
    logic        clr_lvl_q;
    logic        int_q;
    logic        prs_q;
    logic        lp_q;
    logic        init_done;
    logic        rdclr_evt;
    logic [15:0] clr_mask;
    mmi_rdclr_s  rdclr_q;
    // Written on the link side, read here only through synchronisers
    logic        rdclr_tgl_q;
    logic [7:0]  mask_q [7];

    always_ff @(posedge CLK)
    begin
        rstpin_s_q <= {rstpin_s_q[0], MODULE_RESET_N};
        lp_s_q     <= {lp_s_q[0], LOW_POWER_REQUEST};
        flt_s1_q   <= FAULT_IN;
        flt_s2_q   <= flt_s1_q;
        msk_s1_q   <= {mask_q[1], mask_q[0]};
        msk_s2_q   <= msk_s1_q;
        rdclr_s_q  <= {rdclr_s_q[1:0], rdclr_tgl_q};
    end

    // Pin must stay low past the minimum before a reset is taken
    always_ff @(posedge CLK)
    begin
        if (RST || rstpin_s_q[1])
        begin
            rst_low_cnt_q <= 8'h00;
            mod_rst_q     <= 1'b0;
        end
        else if (rst_low_cnt_q != MIN_RST)
            rst_low_cnt_q <= rst_low_cnt_q + 8'h01;
        else
            mod_rst_q <= 1'b1;
    end

    // Count restarts while reset is held, so it runs from the release
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            init_busy_q <= 1'b1;
            init_cnt_q  <= 32'h0;
        end
        else if (mod_rst_q)
        begin
            init_busy_q <= 1'b1;
            init_cnt_q  <= 32'h0;
        end
        else if (init_busy_q)
        begin
            if (init_cnt_q == INIT_LAST)
                init_busy_q <= 1'b0;
            else
                init_cnt_q <= init_cnt_q + 32'h1;
        end
    end

    assign init_done = init_busy_q && !mod_rst_q && init_cnt_q == INIT_LAST;
    assign rdclr_evt = rdclr_s_q[2] ^ rdclr_s_q[1];
    assign clr_mask  = !rdclr_evt ? 16'h0000 :
                       rdclr_q.hi ? {rdclr_q.val, 8'h00} : {8'h00, rdclr_q.val};

    // Set beats a clear in the same cycle; only bits seen by the host clear
    always_ff @(posedge CLK)
    begin
        if (RST || mod_rst_q)
            flags_q <= 16'h0000;
        else
            flags_q <= (flags_q & ~clr_mask)
                       | {7'h00, init_done, flt_s2_q};
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            clr_lvl_q <= 1'b1;
        else
            clr_lvl_q <= mod_rst_q;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            int_q <= 1'b0;
            prs_q <= 1'b0;
            lp_q  <= 1'b0;
        end
        else
        begin
            int_q <= |(flags_q & ~msk_s2_q);
            prs_q <= 1'b0;
            lp_q  <= lp_s_q[1];
        end
    end

    assign INTERRUPT_N_O    = 1'b0;
    assign INTERRUPT_N_OE   = int_q;
    assign MODULE_PRESENT_N = prs_q;
    assign LOW_POWER_STATE  = lp_q;

    // ---------------- SCL domain ----------------
    logic [1:0]  sel_s_q;
    logic [1:0]  clr_s_q;
    mmi_stat_s   stat_s1_q, stat_s2_q;
    logic        rx_q;
    logic [7:0]  sh_q;
    mmi_state_e  st_q;
    logic [2:0]  bcnt_q;
    logic        ack_q;
    logic        oe_q;
    logic [7:0]  ptr_q;
    logic [7:0]  tx_q;
    logic [7:0]  ctrl_q [12];
    logic [7:0]  p3ctl_q [2];
    logic [7:0]  page_q;
    logic [7:0]  rd_byte;
    logic        start_c, stop_c, byte_end, wr_now, adr_hit;

    always_ff @(posedge SCL)
    begin
        rx_q <= SDA_I;
        sh_q <= {sh_q[6:0], SDA_I};
    end

    always_ff @(negedge SCL)
    begin
        sel_s_q   <= {sel_s_q[0], MODULE_SELECT_N};
        clr_s_q   <= {clr_s_q[0], clr_lvl_q};
        stat_s1_q <= '{flags: flags_q, pending: init_busy_q};
        stat_s2_q <= stat_s1_q;
    end

    // SDA moving while SCL is high marks start or stop
    assign start_c  = rx_q && !SDA_I;
    assign stop_c   = !rx_q && SDA_I;
    assign byte_end = !ack_q && bcnt_q == 3'd7 && st_q != ST_IDLE;
    assign wr_now   = byte_end && st_q == ST_WDATA && !start_c && !stop_c && !sel_s_q[1];
    assign adr_hit  = sh_q[7:1] == `MMI_DEV_ADDR;

    always_comb
    begin
        rd_byte = 8'h00;
        if (!ptr_q[7])
        begin
            if (ptr_q == 8'h00)
                rd_byte = `MMI_TYPE_ID;
            else if (ptr_q == `MMI_ADR_STATUS)
                rd_byte = {7'h00, stat_s2_q.pending};
            else if (ptr_q == `MMI_ADR_FLAG0)
                rd_byte = stat_s2_q.flags[7:0];
            else if (ptr_q == `MMI_ADR_FLAG1)
                rd_byte = stat_s2_q.flags[15:8];
            else if (ptr_q >= `MMI_ADR_CTRL_LO && ptr_q <= `MMI_ADR_CTRL_HI)
                rd_byte = ctrl_q[4'(ptr_q - `MMI_ADR_CTRL_LO)];
            else if (ptr_q >= `MMI_ADR_MASK_LO && ptr_q <= `MMI_ADR_MASK_HI)
                rd_byte = mask_q[3'(ptr_q - `MMI_ADR_MASK_LO)];
            else if (ptr_q == `MMI_ADR_PAGE)
                rd_byte = page_q;
        end
        else if (page_q == `MMI_PAGE_ID)
        begin
            if (ptr_q == `MMI_ADR_BASE_ID_CHECK_CODE)
                rd_byte = BASE_ID_CHECK_CODE_VAL;
            else if (ptr_q == `MMI_ADR_EXT_ID_CHECK_CODE)
                rd_byte = EXT_ID_CHECK_CODE_VAL;
            else
                rd_byte = rom0_raw(ptr_q);
        end
        else if (page_q == `MMI_PAGE_THR && ptr_q >= `MMI_ADR_P3CTL_LO
                 && ptr_q <= `MMI_ADR_P3CTL_HI)
            rd_byte = p3ctl_q[ptr_q[0]];
    end

    always_ff @(negedge SCL)
    begin
        if (clr_s_q[1] || sel_s_q[1])
        begin
            st_q   <= ST_IDLE;
            oe_q   <= 1'b0;
            ack_q  <= 1'b0;
            bcnt_q <= 3'd0;
        end
        else if (start_c)
        begin
            st_q   <= ST_DEVADR;
            oe_q   <= 1'b0;
            ack_q  <= 1'b0;
            bcnt_q <= 3'd0;
        end
        else if (stop_c)
        begin
            st_q  <= ST_IDLE;
            oe_q  <= 1'b0;
            ack_q <= 1'b0;
        end
        else if (ack_q)
        begin
            ack_q  <= 1'b0;
            bcnt_q <= 3'd0;
            oe_q   <= 1'b0;
            if (st_q == ST_RDATA)
            begin
                if (rx_q)
                    st_q <= ST_IDLE; // Host ended the read with a nack
                else
                begin
                    oe_q <= !rd_byte[7];
                    tx_q <= {rd_byte[6:0], 1'b0};
                end
            end
        end
        else if (byte_end)
        begin
            ack_q <= 1'b1;
            oe_q  <= 1'b1;
            unique case (st_q)
                ST_DEVADR:
                begin
                    if (!adr_hit)
                    begin
                        st_q  <= ST_IDLE;
                        oe_q  <= 1'b0;
                        ack_q <= 1'b0;
                    end
                    else
                        st_q <= sh_q[0] ? ST_RDATA : ST_PTR;
                end
                ST_PTR:
                begin
                    ptr_q <= sh_q;
                    st_q  <= ST_WDATA;
                end
                ST_WDATA:
                    ptr_q <= ptr_q + 8'h01;
                ST_RDATA:
                begin
                    oe_q  <= 1'b0;
                    ptr_q <= ptr_q + 8'h01;
                end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
        else if (st_q != ST_IDLE)
        begin
            bcnt_q <= bcnt_q + 3'd1;
            if (st_q == ST_RDATA)
            begin
                oe_q <= !tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // Flag bytes are cleared once loaded for sending; data held stable meanwhile
    always_ff @(negedge SCL)
    begin
        if (clr_s_q[1])
            rdclr_tgl_q <= 1'b0;
        else if (ack_q && st_q == ST_RDATA && !rx_q && !start_c && !stop_c
                 && !sel_s_q[1]
                 && (ptr_q == `MMI_ADR_FLAG0 || ptr_q == `MMI_ADR_FLAG1))
        begin
            rdclr_tgl_q <= !rdclr_tgl_q;
            rdclr_q     <= '{hi: ptr_q == `MMI_ADR_FLAG1, val: rd_byte};
        end
    end

    always_ff @(negedge SCL)
    begin
        if (clr_s_q[1])
        begin
            page_q <= 8'h00;
            for (int i = 0; i < 12; i++)
                ctrl_q[i] <= 8'h00;
            for (int i = 0; i < 7; i++)
                mask_q[i] <= 8'h00;
            p3ctl_q[0] <= 8'h00;
            p3ctl_q[1] <= 8'h00;
        end
        else if (wr_now)
        begin
            if (ptr_q >= `MMI_ADR_CTRL_LO && ptr_q <= `MMI_ADR_CTRL_HI)
                ctrl_q[4'(ptr_q - `MMI_ADR_CTRL_LO)] <= sh_q;
            else if (ptr_q >= `MMI_ADR_MASK_LO && ptr_q <= `MMI_ADR_MASK_HI)
                mask_q[3'(ptr_q - `MMI_ADR_MASK_LO)] <= sh_q;
            else if (ptr_q == `MMI_ADR_PAGE)
                page_q <= sh_q;
            else if (page_q == `MMI_PAGE_THR && ptr_q >= `MMI_ADR_P3CTL_LO
                     && ptr_q <= `MMI_ADR_P3CTL_HI)
                p3ctl_q[ptr_q[0]] <= sh_q;
        end
    end

    assign SDA_O  = 1'b0;
    assign SDA_OE = oe_q;

    // ---------------- Checks ----------------
    sequence s_rst_release;
        mod_rst_q ##1 !mod_rst_q;
    endsequence

    sequence s_init_finish;
        init_busy_q ##1 !init_busy_q;
    endsequence

    property p_reset_needs_length;
        @(posedge CLK) disable iff (RST)
        $rose(mod_rst_q) |-> !rstpin_s_q[1] && $past(rst_low_cnt_q) == MIN_RST;
    endproperty
    a_reset_needs_length: assert property (p_reset_needs_length)
        else $error("module reset taken without minimum low time");

    property p_init_from_release;
        @(posedge CLK) disable iff (RST)
        s_rst_release |-> init_busy_q && init_cnt_q == 32'h0 ##1 init_cnt_q == 32'h1;
    endproperty
    a_init_from_release: assert property (p_init_from_release)
        else $error("init count did not start at reset release");

    property p_completion_int;
        @(posedge CLK) disable iff (RST || mod_rst_q)
        s_init_finish ##0 !msk_s2_q[8] |-> flags_q[8] ##1 INTERRUPT_N_OE && !init_busy_q;
    endproperty
    a_completion_int: assert property (p_completion_int)
        else $error("no completion interrupt with pending clear");

    property p_powerup_busy;
        @(posedge CLK) disable iff (RST)
        $fell(RST) |-> init_busy_q && !flags_q[8];
    endproperty
    a_powerup_busy: assert property (p_powerup_busy)
        else $error("power-up did not start initialisation");

    property p_low_power;
        @(posedge CLK) disable iff (RST)
        lp_s_q[1] |=> LOW_POWER_STATE;
    endproperty
    a_low_power: assert property (p_low_power)
        else $error("low power state not entered");

    property p_present_low;
        @(posedge CLK) disable iff (RST)
        !MODULE_PRESENT_N && !INTERRUPT_N_O;
    endproperty
    a_present_low: assert property (p_present_low)
        else $error("presence or open-drain level driven high");

    property p_int_release;
        @(posedge CLK) disable iff (RST)
        (flags_q & ~msk_s2_q) == 16'h0000 |=> !INTERRUPT_N_OE;
    endproperty
    a_int_release: assert property (p_int_release)
        else $error("interrupt held without an active flag");

    property p_set_wins;
        @(posedge CLK) disable iff (RST || mod_rst_q)
        flt_s2_q[0] |=> flags_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("fault flag lost against a clear");

    property p_deselect_quiet;
        @(negedge SCL) disable iff (clr_s_q[1])
        sel_s_q[1] |=> !SDA_OE && st_q == ST_IDLE;
    endproperty
    a_deselect_quiet: assert property (p_deselect_quiet)
        else $error("deselected module drove the bus");

    property p_ptr_step;
        @(negedge SCL) disable iff (clr_s_q[1])
        wr_now |=> ptr_q == $past(ptr_q) + 8'h01;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("pointer did not advance after a byte");

endmodule

//--- bench/mmi_host.sv
`timescale 1ns/10ps
module mmi_host
(
    output logic      scl,
    output wire logic sda_i,
    input  wire logic sda_o,
    input  wire logic sda_oe
);
    logic pull_q;

    // Pull-up on the wire: high unless a party pulls low
    assign sda_i = !(pull_q || (sda_oe && !sda_o));

    initial
    begin
        scl = 1'b0;
        pull_q = 1'b0;
    end

    task automatic bit_x(input logic b, output logic r);
        #20 pull_q = !b;
        #20 scl = 1'b1;
        r = sda_i;
        #40 scl = 1'b0;
    endtask

    task automatic start();
        #20 pull_q = 1'b0;
        #20 scl = 1'b1;
        #20 pull_q = 1'b1;
        #20 scl = 1'b0;
    endtask

    task automatic stop();
        #20 pull_q = 1'b1;
        #20 scl = 1'b1;
        #20 pull_q = 1'b0;
        #20 scl = 1'b0;
    endtask

    // Clock stands still between frames, so runs are explicit
    task automatic idle(input int n);
        pull_q = 1'b0;
        repeat (n)
        begin
            #40 scl = 1'b1;
            #40 scl = 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask

    task automatic rd(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, b[i]);
        bit_x(last, r);
    endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/10ps
`include "mmi_defines.svh"
module testbench;
    localparam int INIT = 2000;
    localparam int OFF  = 40;
    logic       clk = 1'b0;
    logic       rst;
    logic       sel_n;
    logic       mrst_n;
    logic       lpr;
    logic [7:0] fault;
    wire        scl;
    wire        sda_i;
    wire        sda_o;
    wire        sda_oe;
    wire        lps;
    wire        present_n;
    wire        int_o;
    wire        int_oe;
    wire        int_n;
    int         err_count = 0;
    int         comparisons = 0;
    int         c;
    logic [7:0] s8;
    logic [7:0] l8;
    logic       ack;

    // Host pull-up on the interrupt line
    assign int_n = !(int_oe && !int_o);

    always #12.5 clk = ~clk;

    mmi_host host_u (.scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

    mmi_top #(.INIT_CYCLES(INIT), .INTERRUPT_N_OFF_CYCLES(OFF)) dut_u (
        .CLK(clk), .RST(rst), .SCL(scl), .SDA_I(sda_i), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .MODULE_SELECT_N(sel_n), .MODULE_RESET_N(mrst_n),
        .LOW_POWER_REQUEST(lpr), .FAULT_IN(fault), .LOW_POWER_STATE(lps),
        .MODULE_PRESENT_N(present_n), .INTERRUPT_N_O(int_o),
        .INTERRUPT_N_OE(int_oe));

    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        host_u.start();
        host_u.wr(8'hA0, ack);
        host_u.wr(a, ack);
        host_u.wr(d, ack);
        check(ack, 1'b1);
        host_u.stop();
    endtask

    // Sum of all but the last byte lands in s8, last byte in l8
    task automatic get(input logic [7:0] a, input int n);
        logic [7:0] b;
        s8 = 8'h00;
        host_u.start();
        host_u.wr(8'hA0, ack);
        host_u.wr(a, ack);
        host_u.start();
        host_u.wr(8'hA1, ack);
        check(ack, 1'b1);
        for (int i = 1; i <= n; i++)
        begin
            host_u.rd(i == n, b);
            if (i < n)
                s8 += b;
        end
        l8 = b;
        host_u.stop();
    endtask

    task automatic probe(input logic [7:0] dev);
        host_u.start();
        host_u.wr(dev, ack);
        host_u.stop();
    endtask

    task automatic wait_int(input logic v, input int lim);
        c = 0;
        while (int_n !== v && c < lim)
        begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask

    task automatic pulse(input logic [7:0] v);
        @(posedge clk) fault <= v;
        repeat (4) @(posedge clk);
        fault <= 8'h00;
    endtask

    initial
    begin
        #1000000;
        err_count++;
        end_sim();
    end

    initial
    begin
        rst = 1'b1;
        sel_n = 1'b0;
        mrst_n = 1'b1;
        lpr = 1'b0;
        fault = 8'h00;
        // Link side clears only while SCL runs, so clock it under reset
        fork
            host_u.idle(5);
            repeat (20) @(posedge clk);
        join
        rst <= 1'b0;
        host_u.idle(4);
        check(present_n, 1'b0);
        check(int_o, 1'b0);
        get(`MMI_ADR_STATUS, 1);
        check(l8[0], 1'b1);
        wait_int(1'b0, INIT + 20);
        check(int_n, 1'b0);
        get(`MMI_ADR_STATUS, 1);
        check(l8[0], 1'b0);
        get(`MMI_ADR_FLAG1, 1);
        check(l8[0], 1'b1);
        wait_int(1'b1, OFF);
        check(int_n, 1'b1);
        @(posedge clk) lpr <= 1'b1;
        @(posedge clk) #1 check(lps, 1'b0);
        repeat (3) @(posedge clk);
        #1 check(lps, 1'b1);
        @(posedge clk) lpr <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check(lps, 1'b0);
        probe(8'hA2);
        check(ack, 1'b0);
        @(posedge clk) sel_n <= 1'b1;
        host_u.idle(4);
        probe(8'hA0);
        check(ack, 1'b0);
        @(posedge clk) sel_n <= 1'b0;
        host_u.idle(4);
        probe(8'hA0);
        check(ack, 1'b1);
        put(8'h56, 8'h3C);
        get(8'h56, 1);
        check(l8, 8'h3C);
        put(8'h6A, 8'hC3);
        get(8'h6A, 1);
        check(l8, 8'hC3);
        put(8'h00, 8'hFF);
        get(8'h00, 1);
        check(l8, `MMI_TYPE_ID);
        put(8'h52, 8'h77);
        get(8'h52, 1);
        check(l8, 8'h00);
        put(`MMI_ADR_PAGE, `MMI_PAGE_THR);
        get(`MMI_ADR_PAGE, 1);
        check(l8, `MMI_PAGE_THR);
        put(`MMI_ADR_P3CTL_HI, 8'hA5);
        get(`MMI_ADR_P3CTL_HI, 1);
        check(l8, 8'hA5);
        put(8'h80, 8'h11);
        get(8'h80, 1);
        check(l8, 8'h00);
        put(`MMI_ADR_PAGE, `MMI_PAGE_ID);
        get(`MMI_ADR_RATE, 1);
        check(l8, `MMI_RATE_VAL);
        get(`MMI_ADR_WAVE, 2);
        check({s8, l8}, `MMI_WAVE_VAL);
        get(`MMI_ADR_TOL, 2);
        check({s8, l8}, `MMI_TOL_VAL);
        get(8'h80, 64);
        check(l8, s8);
        get(8'hC0, 32);
        check(l8, s8);
        get(8'hFF, 2);
        check(l8, `MMI_TYPE_ID);
        pulse(8'h81);
        wait_int(1'b0, 20);
        check(int_n, 1'b0);
        get(`MMI_ADR_FLAG0, 1);
        check(l8, 8'h81);
        wait_int(1'b1, OFF);
        check(int_n, 1'b1);
        put(`MMI_ADR_MASK_LO, 8'h81);
        pulse(8'h81);
        repeat (50) @(posedge clk);
        check(int_n, 1'b1);
        get(`MMI_ADR_FLAG0, 1);
        check(l8, 8'h81);
        pulse(8'h7E);
        wait_int(1'b0, 20);
        check(int_n, 1'b0);
        get(`MMI_ADR_FLAG0, 1);
        check(l8, 8'h7E);
        wait_int(1'b1, OFF);
        check(int_n, 1'b1);
        // Too short a pulse must leave settings alone
        @(posedge clk) mrst_n <= 1'b0;
        repeat (40) @(posedge clk);
        mrst_n <= 1'b1;
        host_u.idle(4);
        get(8'h56, 1);
        check(l8, 8'h3C);
        @(posedge clk) mrst_n <= 1'b0;
        host_u.idle(40);
        @(posedge clk) mrst_n <= 1'b1;
        wait_int(1'b0, INIT + 50);
        check(c >= INIT && c <= INIT + 10, 1'b1);
        host_u.idle(4);
        get(8'h56, 1);
        check(l8, 8'h00);
        get(`MMI_ADR_MASK_LO, 1);
        check(l8, 8'h00);
        end_sim();
    end
endmodule
